// >>> include/ubg_pkg.sv
// ubg_pkg: constants, register map and types for the serial data buffers
// and bit-rate generator; assumes one 40 MHz clock and a byte-wide register port.

package ubg_pkg;

   // ----------------------------------------------------------------
   // register map
   // ----------------------------------------------------------------
   localparam int ADDR_W = 4;
   localparam logic [3:0] OFS_RX_DATA = 4'h0;
   localparam logic [3:0] OFS_TX_DATA = 4'h1;
   localparam logic [3:0] OFS_DIV_LOW = 4'h2;
   localparam logic [3:0] OFS_DIV_HIGH = 4'h3;
   localparam logic [3:0] OFS_RX_CTRL = 4'h4;
   localparam logic [3:0] OFS_TX_CTRL = 4'h5;
   localparam logic [3:0] OFS_BAUD_CTRL = 4'h6;

   // ----------------------------------------------------------------
   // field positions and masks
   // ----------------------------------------------------------------
   localparam int TXC_SYNC = 4;
   localparam int TXC_HIGH_SPEED = 2;
   localparam int TXC_SHIFT_EMPTY = 1;
   localparam int TXC_NINTH = 0;
   localparam int RXC_NINTH = 0;
   localparam int BDC_WIDE = 3;
   localparam logic [7:0] TXC_WMASK = 8'hfd;
   localparam logic [7:0] RXC_WMASK = 8'hf8;
   localparam logic [7:0] BDC_WMASK = 8'h1b;
   localparam logic [7:0] BYTE_ZERO = 8'h00;

   // ----------------------------------------------------------------
   // prescaler terminal counts and their spans
   // ----------------------------------------------------------------
   localparam logic [5:0] PRE_SYNC_TC = 6'h03;
   localparam logic [5:0] PRE_WIDE_TC = 6'h0f;
   localparam logic [5:0] PRE_HIGH_TC = 6'h0f;
   localparam logic [5:0] PRE_LOW_TC = 6'h3f;
   localparam int SPAN_SYNC = 4;
   localparam int SPAN_WIDE = 16;
   localparam int SPAN_LOW = 64;
   localparam int CLK_HZ = 40000000;

   // one character: ninth bit above the data byte
   typedef struct packed {
      logic ninth;
      logic [7:0] data;
   } ubg_char_t;

endpackage

// >>> core/ubg_buf.sv
// ubg_buf: two-entry buffer with valid/ready on both sides
// assumes one clock, synchronous active-high reset and a clock enable.
`timescale 1ns/1ps
`default_nettype none

module ubg_buf #(
   parameter int W = 9
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic in_valid,
   input wire logic [W-1:0] in_data,
   output logic in_ready,
   output logic out_valid,
   output logic [W-1:0] out_data,
   input wire logic out_ready
);

   typedef struct packed {
      logic [1:0][W-1:0] slot;
      logic [1:0] cnt;
   } ubg_buf_state_t;

   localparam logic [1:0] CNT_EMPTY = 2'h0;
   localparam logic [1:0] CNT_ONE = 2'h1;
   localparam logic [1:0] CNT_FULL = 2'h2;

   ubg_buf_state_t s_r;
   ubg_buf_state_t s_nxt;
   logic push;
   logic pop;

   // handshake from the count flops
   assign in_ready = (s_r.cnt != CNT_FULL);
   assign out_valid = (s_r.cnt != CNT_EMPTY);
   assign out_data = s_r.slot[0];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   // shift on pop, fill the first free slot on push
   always_comb begin
      s_nxt = s_r;
      if (pop) begin
         s_nxt.slot[0] = s_r.slot[1];
      end
      if (push) begin
         if (s_r.cnt == CNT_EMPTY || (s_r.cnt == CNT_ONE && pop)) begin
            s_nxt.slot[0] = in_data;
         end else begin
            s_nxt.slot[1] = in_data;
         end
      end
      s_nxt.cnt = 2'(s_r.cnt + {1'b0, push} - {1'b0, pop});
   end

   // state register, frozen while ce is low
   always_ff @(posedge clk) begin
      if (rst) begin
         s_r <= '0;
      end else if (ce) begin
         s_r <= s_nxt;
      end
   end

endmodule

`default_nettype wire

// >>> core/ubg_top.sv
// ubg_top: serial data buffers and bit-rate generator with its registers
// assumes frame shifters on the same clock and a strobed byte register port.
//
// The strobed register port and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none

module ubg_top #(
   parameter int ADDR_W = ubg_pkg::ADDR_W
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [7:0] rdata,
   input wire logic rx_char_valid,
   input wire ubg_pkg::ubg_char_t rx_char,
   output logic rx_char_ready,
   output logic rx_avail,
   output logic tx_char_valid,
   output ubg_pkg::ubg_char_t tx_char,
   input wire logic tx_char_ready,
   output logic tx_room,
   output logic rate_tick,
   output logic [7:0] rx_ctrl,
   output logic [7:0] tx_ctrl,
   output logic [7:0] baud_ctrl
);

   typedef struct packed {
      logic [7:0] rdata;
      logic [7:0] txd;
      logic [7:0] div_low;
      logic [7:0] div_high;
      logic [7:0] rcs;
      logic [7:0] tcs;
      logic [7:0] bcn;
      logic [5:0] pre;
      logic [15:0] cnt;
      logic tick;
   } ubg_state_t;

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------

   // address match
   function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [3:0] ofs);
      hit = (a == ADDR_W'(ofs));
   endfunction

   // divisor in effect for given control and divisor bytes
   function automatic logic [15:0] div_of(input logic [7:0] bc, input logic [7:0] hi,
                                          input logic [7:0] lo);
      div_of = bc[ubg_pkg::BDC_WIDE] ? {hi, lo} : {ubg_pkg::BYTE_ZERO, lo};
   endfunction

   // prescaler terminal count from the mode bits
   // span per mode
   function automatic logic [5:0] pre_tc(input logic sync, input logic wide,
                                         input logic hs);
      if (sync) begin
         pre_tc = ubg_pkg::PRE_SYNC_TC;
      end else if (wide) begin
         pre_tc = ubg_pkg::PRE_WIDE_TC;
      end else if (hs) begin
         pre_tc = ubg_pkg::PRE_HIGH_TC;
      end else begin
         pre_tc = ubg_pkg::PRE_LOW_TC;
      end
   endfunction

   ubg_state_t s_r;
   ubg_state_t s_nxt;
   logic rx_head_valid;
   ubg_pkg::ubg_char_t rx_head;
   logic rx_pop;
   logic tx_push;
   logic tx_in_ready;
   logic restart;
   logic [15:0] div_now;
   logic [5:0] tc_now;
   logic [7:0] rcs_rd;
   logic [7:0] tcs_rd;
   ubg_pkg::ubg_char_t tx_word;

   // ----------------------------------------------------------------
   // character buffers
   // ----------------------------------------------------------------

   // receive double buffer
   // character held with ninth bit
   ubg_buf #(.W(9)) u_rx_buf (
      .clk(clk),
      .rst(rst),
      .ce(ce),
      .in_valid(rx_char_valid),
      .in_data(rx_char),
      .in_ready(rx_char_ready),
      .out_valid(rx_head_valid),
      .out_data(rx_head),
      .out_ready(rx_pop)
   );

   // transmit double buffer
   // character held with ninth bit
   ubg_buf #(.W(9)) u_tx_buf (
      .clk(clk),
      .rst(rst),
      .ce(ce),
      .in_valid(tx_push),
      .in_data(tx_word),
      .in_ready(tx_in_ready),
      .out_valid(tx_char_valid),
      .out_data(tx_char),
      .out_ready(tx_char_ready)
   );

   // buffer strobes and status levels
   // read pops head
   assign rx_pop = rd && hit(addr, ubg_pkg::OFS_RX_DATA);
   assign tx_push = wr && hit(addr, ubg_pkg::OFS_TX_DATA);
   assign tx_word = '{ninth: s_r.tcs[ubg_pkg::TXC_NINTH], data: wdata};
   assign rx_avail = rx_head_valid;
   assign tx_room = tx_in_ready;

   // ----------------------------------------------------------------
   // registers and rate counter
   // ----------------------------------------------------------------

   assign restart = wr && (hit(addr, ubg_pkg::OFS_DIV_LOW) || hit(addr, ubg_pkg::OFS_DIV_HIGH)
                           || hit(addr, ubg_pkg::OFS_TX_CTRL)
                           || hit(addr, ubg_pkg::OFS_BAUD_CTRL));
   assign div_now = div_of(s_r.bcn, s_r.div_high, s_r.div_low);
   assign tc_now = pre_tc(s_r.tcs[ubg_pkg::TXC_SYNC], s_r.bcn[ubg_pkg::BDC_WIDE],
                          s_r.tcs[ubg_pkg::TXC_HIGH_SPEED]);

   // next state: writes, read data and counting
   always_comb begin
      s_nxt = s_r;
      rcs_rd = s_r.rcs;
      tcs_rd = s_r.tcs;
      rcs_rd[ubg_pkg::RXC_NINTH] = rx_head.ninth;
      tcs_rd[ubg_pkg::TXC_SHIFT_EMPTY] = !tx_char_valid;
      if (wr) begin
         unique case (1'b1)
            hit(addr, ubg_pkg::OFS_TX_DATA): s_nxt.txd = tx_in_ready ? wdata : s_r.txd;
            hit(addr, ubg_pkg::OFS_DIV_LOW): s_nxt.div_low = wdata;
            hit(addr, ubg_pkg::OFS_DIV_HIGH): s_nxt.div_high = wdata;
            hit(addr, ubg_pkg::OFS_RX_CTRL): s_nxt.rcs = wdata & ubg_pkg::RXC_WMASK;
            hit(addr, ubg_pkg::OFS_TX_CTRL): s_nxt.tcs = wdata & ubg_pkg::TXC_WMASK;
            hit(addr, ubg_pkg::OFS_BAUD_CTRL): s_nxt.bcn = wdata & ubg_pkg::BDC_WMASK;
            default: s_nxt.txd = s_r.txd;
         endcase
      end
      // read data stands one cycle only
      s_nxt.rdata = ubg_pkg::BYTE_ZERO;
      if (rd) begin
         unique case (1'b1)
            hit(addr, ubg_pkg::OFS_RX_DATA): s_nxt.rdata = rx_head.data;
            hit(addr, ubg_pkg::OFS_TX_DATA): s_nxt.rdata = s_r.txd;
            hit(addr, ubg_pkg::OFS_DIV_LOW): s_nxt.rdata = s_r.div_low;
            hit(addr, ubg_pkg::OFS_DIV_HIGH): s_nxt.rdata = s_r.div_high;
            hit(addr, ubg_pkg::OFS_RX_CTRL): s_nxt.rdata = rcs_rd;
            hit(addr, ubg_pkg::OFS_TX_CTRL): s_nxt.rdata = tcs_rd;
            hit(addr, ubg_pkg::OFS_BAUD_CTRL): s_nxt.rdata = s_r.bcn;
            default: s_nxt.rdata = ubg_pkg::BYTE_ZERO;
         endcase
      end
      s_nxt.tick = 1'b0;
      if (restart) begin
         s_nxt.pre = '0;
         s_nxt.cnt = div_of(s_nxt.bcn, s_nxt.div_high, s_nxt.div_low);
      end else if (s_r.pre >= tc_now) begin
         s_nxt.pre = '0;
         if (s_r.cnt == '0) begin
            s_nxt.cnt = div_now;
            s_nxt.tick = 1'b1;
         end else begin
            s_nxt.cnt = 16'(s_r.cnt - 16'h0001);
         end
      end else begin
         s_nxt.pre = 6'(s_r.pre + 6'h01);
      end
   end

   // state register, frozen while ce is low
   always_ff @(posedge clk) begin
      if (rst) begin
         s_r <= '0;
      end else if (ce) begin
         s_r <= s_nxt;
      end
   end

   // outputs straight from flops
   assign rdata = s_r.rdata;
   assign rate_tick = s_r.tick;
   assign rx_ctrl = s_r.rcs;
   assign tx_ctrl = s_r.tcs;
   assign baud_ctrl = s_r.bcn;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------

   // cycles since the last tick or restart
   logic [23:0] gap_r;
   always_ff @(posedge clk) begin
      if (rst) begin
         gap_r <= '0;
      end else if (ce) begin
         if (restart) begin
            gap_r <= '0;
         end else if (s_r.tick) begin
            gap_r <= 24'h000001;
         end else begin
            gap_r <= 24'(gap_r + 24'h000001);
         end
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   AST_RX_READ: assert property (ce && rx_pop |=> rdata == $past(rx_head.data))
      else $error("receive read returned wrong byte");
   AST_RX_HOLD: assert property (ce && rx_head_valid && !rx_pop |=>
      rx_head_valid && rx_head == $past(rx_head))
      else $error("held receive character changed");
   AST_TX_TAKE: assert property (ce && tx_push && tx_in_ready |=> tx_char_valid)
      else $error("transmit write lost");
   AST_LOW_RESTART: assert property (ce && wr && hit(addr, ubg_pkg::OFS_DIV_LOW) |=>
      s_r.pre == '0 && s_r.cnt == div_now && !rate_tick)
      else $error("low divisor write did not restart counter");
   AST_HIGH_RESTART: assert property (ce && wr && hit(addr, ubg_pkg::OFS_DIV_HIGH) |=>
      s_r.pre == '0 && s_r.cnt == div_now)
      else $error("high divisor write did not restart counter");
   AST_HIGH_IGNORED: assert property (rate_tick && !baud_ctrl[ubg_pkg::BDC_WIDE] |->
      s_r.cnt == {ubg_pkg::BYTE_ZERO, s_r.div_low})
      else $error("high divisor byte used in narrow mode");
   AST_DIV_JOIN: assert property (rate_tick && baud_ctrl[ubg_pkg::BDC_WIDE] |->
      s_r.cnt == {s_r.div_high, s_r.div_low})
      else $error("wide divisor not high over low");
   AST_RATE_LOW: assert property (rate_tick && !tx_ctrl[ubg_pkg::TXC_SYNC] &&
      !baud_ctrl[ubg_pkg::BDC_WIDE] && !tx_ctrl[ubg_pkg::TXC_HIGH_SPEED] |->
      gap_r == 24'(ubg_pkg::SPAN_LOW * (int'(div_now) + 1)))
      else $error("low speed period wrong");
   AST_RATE_WIDE: assert property (rate_tick && !tx_ctrl[ubg_pkg::TXC_SYNC] &&
      baud_ctrl[ubg_pkg::BDC_WIDE] && !tx_ctrl[ubg_pkg::TXC_HIGH_SPEED] |->
      gap_r == 24'(ubg_pkg::SPAN_WIDE * (int'(div_now) + 1)))
      else $error("wide divider period wrong");
   AST_RATE_SYNC: assert property (rate_tick && tx_ctrl[ubg_pkg::TXC_SYNC] &&
      !baud_ctrl[ubg_pkg::BDC_WIDE] |->
      gap_r == 24'(ubg_pkg::SPAN_SYNC * (int'(div_now) + 1)))
      else $error("synchronous period wrong");
   AST_TICK_PULSE: assert property (ce && rate_tick |=> !rate_tick)
      else $error("rate tick longer than one cycle");
   AST_RATE_HIGH: assert property (rate_tick && !tx_ctrl[ubg_pkg::TXC_SYNC] &&
      !baud_ctrl[ubg_pkg::BDC_WIDE] && tx_ctrl[ubg_pkg::TXC_HIGH_SPEED] |->
      gap_r == 24'(ubg_pkg::SPAN_WIDE * (int'(div_now) + 1)))
      else $error("high speed period wrong");
   AST_RATE_SYNC_WIDE: assert property (rate_tick && tx_ctrl[ubg_pkg::TXC_SYNC] &&
      baud_ctrl[ubg_pkg::BDC_WIDE] |->
      gap_r == 24'(ubg_pkg::SPAN_SYNC * (int'(div_now) + 1)))
      else $error("synchronous wide period wrong");
   // write to a full buffer dropped
   AST_TX_DROP: assert property (ce && tx_push && !tx_in_ready |=>
      s_r.txd == $past(s_r.txd))
      else $error("transmit write to a full buffer taken");
   AST_RDATA_IDLE: assert property (ce && !rd |=> rdata == ubg_pkg::BYTE_ZERO)
      else $error("read data outside the answer cycle");

   // main scenarios
   COV_RX_FULL: cover property (!rx_char_ready ##1 rx_pop);
   COV_TX_FULL: cover property (tx_push && !tx_in_ready);
   COV_WIDE_TICK: cover property (rate_tick && baud_ctrl[ubg_pkg::BDC_WIDE]);
   COV_SYNC_TICK: cover property (rate_tick && tx_ctrl[ubg_pkg::TXC_SYNC]);
   COV_CE_HOLD: cover property (!ce ##1 ce);

endmodule

`default_nettype wire

// >>> dv/ubg_shifter_model.sv
// ubg_shifter_model: stand-in for the frame shifters on both streams
// assumes the bench pushes receive characters and reads back what was sent.
`timescale 1ns/1ps
`default_nettype none

module ubg_shifter_model (
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic stall,
   input wire logic rx_char_ready,
   output logic rx_char_valid,
   output ubg_pkg::ubg_char_t rx_char,
   input wire logic tx_char_valid,
   input wire ubg_pkg::ubg_char_t tx_char,
   output logic tx_char_ready
);
   ubg_pkg::ubg_char_t rx_q[$];
   ubg_pkg::ubg_char_t tx_got[$];

   // quiet lines at time zero
   initial begin
      rx_char_valid = 1'b0;
      rx_char = '0;
      tx_char_ready = 1'b0;
   end

   // offer characters until taken, scramble the data lines when idle
   always @(posedge clk) begin
      if (!rst && ce && rx_char_valid && rx_char_ready)
         void'(rx_q.pop_front());
      if (rx_q.size() > 0) begin
         rx_char_valid <= 1'b1;
         rx_char <= rx_q[0];
      end else begin
         rx_char_valid <= 1'b0;
         rx_char <= ~rx_char;
      end
      if (!rst && ce && tx_char_valid && tx_char_ready)
         tx_got.push_back(tx_char);
      tx_char_ready <= !stall;
   end
endmodule

`default_nettype wire

// >>> dv/ubg_top_tb.sv
// ubg_top_tb: self-checking bench for the data buffers and rate generator
// assumes the shifter model sits on both character streams.
`timescale 1ns/1ps
`default_nettype none

`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin fail_count++; \
   $display("Error at %0t: got %h expected %h", $time, g, e); end end

module ubg_top_tb;
   logic clk, rst, ce, wr, rd, stall;
   logic [3:0] addr;
   logic [7:0] wdata, rdata, rx_ctrl, tx_ctrl, baud_ctrl, got, a, b;
   logic rx_char_valid, rx_char_ready, rx_avail, tx_char_valid, tx_char_ready;
   logic tx_room, rate_tick;
   ubg_pkg::ubg_char_t rx_char, tx_char, c;
   ubg_pkg::ubg_char_t exp_q[$];
   int fail_count, comparisons, seed, k;

   ubg_top u_ubg_top (.clk(clk), .rst(rst), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr),
      .rd(rd), .rdata(rdata), .rx_char_valid(rx_char_valid), .rx_char(rx_char),
      .rx_char_ready(rx_char_ready), .rx_avail(rx_avail), .tx_char_valid(tx_char_valid),
      .tx_char(tx_char), .tx_char_ready(tx_char_ready), .tx_room(tx_room),
      .rate_tick(rate_tick), .rx_ctrl(rx_ctrl), .tx_ctrl(tx_ctrl), .baud_ctrl(baud_ctrl));

   ubg_shifter_model u_ubg_shifter_model (.clk(clk), .rst(rst), .ce(ce), .stall(stall),
      .rx_char_ready(rx_char_ready), .rx_char_valid(rx_char_valid), .rx_char(rx_char),
      .tx_char_valid(tx_char_valid), .tx_char(tx_char), .tx_char_ready(tx_char_ready));

   // ---------------------------------------------
   // clock and watchdog
   // ---------------------------------------------
   // 40 MHz clock
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   // cut a hang short
   initial begin
      repeat (100000) @(posedge clk);
      fail_count++;
      $display("Error at %0t: timeout %h %h", $time, 0, 1);
      conclude();
   end

   // ---------------------------------------------
   // register port tasks
   // ---------------------------------------------
   task automatic wreg(input logic [3:0] ad, input logic [7:0] d);
      @(posedge clk);
      addr <= ad;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   task automatic rreg(input logic [3:0] ad, output logic [7:0] d);
      @(posedge clk);
      addr <= ad;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask

   // set a mode, then time two periods from the last divisor write
   task automatic rate_mode(input logic s, h, w, last_hi, input logic [7:0] lo, hi);
      int p, k;
      p = (s ? 4 : ((w || h) ? 16 : 64)) * ((w ? {hi, lo} : {8'h00, lo}) + 1);
      wreg(ubg_pkg::OFS_BAUD_CTRL, {4'h0, w, 3'h0});
      wreg(ubg_pkg::OFS_TX_CTRL, {3'h0, s, 1'b0, h, 2'h0});
      if (last_hi) begin
         wreg(ubg_pkg::OFS_DIV_LOW, lo);
         wreg(ubg_pkg::OFS_DIV_HIGH, hi);
      end else begin
         wreg(ubg_pkg::OFS_DIV_HIGH, hi);
         wreg(ubg_pkg::OFS_DIV_LOW, lo);
      end
      // count edges from the restarting write
      k = 0;
      #1;
      repeat (2) begin
         while (rate_tick !== 1'b1 && k < 70000) begin
            @(posedge clk);
            #1 k++;
         end
         `CHK(k, p)
         @(posedge clk);
         #1 k = 1;
      end
   endtask

   task automatic conclude;
      $display("comparisons %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // ---------------------------------------------
   // main sequence
   // ---------------------------------------------
   initial begin
      seed = 58752;
      rst = 1'b1;
      ce = 1'b1;
      wr = 1'b0;
      rd = 1'b0;
      stall = 1'b0;
      addr = 4'h0;
      wdata = 8'h00;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      // reset values, unmapped places included
      for (int i = 0; i < 10; i++) begin
         rreg(4'(i), got);
         `CHK(got, (i == 5) ? 8'h02 : 8'h00)
      end
      `CHK({rx_avail, tx_room}, 2'b01)
      // divisor and control readback
      a = 8'($random(seed));
      wreg(ubg_pkg::OFS_DIV_LOW, a);
      rreg(ubg_pkg::OFS_DIV_LOW, got);
      `CHK(got, a)
      wreg(ubg_pkg::OFS_DIV_HIGH, ~a);
      rreg(ubg_pkg::OFS_DIV_HIGH, got);
      `CHK(got, ~a)
      wreg(ubg_pkg::OFS_BAUD_CTRL, a);
      rreg(ubg_pkg::OFS_BAUD_CTRL, got);
      `CHK(got, a & ubg_pkg::BDC_WMASK)
      $display("test registers done");
      // rate formulas, every mode with one row or more
      rate_mode(1'b0, 1'b0, 1'b0, 1'b0, 8'h02, 8'h00);
      rate_mode(1'b0, 1'b0, 1'b0, 1'b1, 8'h03, 8'h01);
      rate_mode(1'b0, 1'b0, 1'b1, 1'b1, 8'h03, 8'h01);
      rate_mode(1'b0, 1'b1, 1'b0, 1'b0, 8'h04, 8'h00);
      rate_mode(1'b1, 1'b1, 1'b0, 1'b0, 8'h05, 8'h00);
      rate_mode(1'b1, 1'b0, 1'b1, 1'b0, 8'h01, 8'h01);
      rate_mode(1'b1, 1'b0, 1'b0, 1'b0, 8'($random(seed)), 8'h00);
      // clock enable low for ten edges stretches one sync period by ten
      wreg(ubg_pkg::OFS_DIV_LOW, 8'h05);
      @(posedge clk);
      ce <= 1'b0;
      repeat (10) @(posedge clk);
      ce <= 1'b1;
      k = 11;
      #1;
      while (rate_tick !== 1'b1 && k < 200) begin
         @(posedge clk);
         #1 k++;
      end
      `CHK(k, ubg_pkg::SPAN_SYNC * 6 + 10)
      $display("test rate done");
      // receive: three characters, two held, ninth bit read first
      for (int i = 0; i < 3; i++) begin
         c = 9'($random(seed));
         exp_q.push_back(c);
         u_ubg_shifter_model.rx_q.push_back(c);
      end
      repeat (6) @(posedge clk);
      #1 `CHK({rx_char_ready, rx_avail}, 2'b01)
      for (int i = 0; i < 3; i++) begin
         rreg(ubg_pkg::OFS_RX_CTRL, got);
         `CHK(got[0], exp_q[0].ninth)
         wreg(ubg_pkg::OFS_RX_DATA, ~exp_q[0].data);
         rreg(ubg_pkg::OFS_RX_DATA, got);
         `CHK(got, exp_q[0].data)
         void'(exp_q.pop_front());
         repeat (3) @(posedge clk);
      end
      #1 `CHK(rx_avail, 1'b0)
      $display("test receive done");
      // transmit: fill while stalled, third write dropped, then drain
      @(posedge clk);
      stall <= 1'b1;
      a = 8'($random(seed));
      b = 8'($random(seed));
      wreg(ubg_pkg::OFS_TX_CTRL, 8'h01);
      wreg(ubg_pkg::OFS_TX_DATA, a);
      exp_q.push_back({1'b1, a});
      wreg(ubg_pkg::OFS_TX_CTRL, 8'h00);
      wreg(ubg_pkg::OFS_TX_DATA, b);
      exp_q.push_back({1'b0, b});
      wreg(ubg_pkg::OFS_TX_DATA, ~b);
      rreg(ubg_pkg::OFS_TX_DATA, got);
      `CHK(got, b)
      `CHK({tx_room, tx_char_valid}, 2'b01)
      for (int i = 0; i < 8; i++) begin
         @(posedge clk);
         stall <= 1'($random(seed));
      end
      @(posedge clk);
      stall <= 1'b0;
      repeat (6) @(posedge clk);
      #1 `CHK(u_ubg_shifter_model.tx_got.size(), 2)
      for (int i = 0; i < 2; i++)
         `CHK(u_ubg_shifter_model.tx_got[i], exp_q[i])
      `CHK({tx_room, tx_char_valid}, 2'b10)
      $display("test transmit done");
      conclude();
   end
endmodule

`default_nettype wire
